// >>> core/exec_pkg.sv
// constants, field layouts and types shared by the instruction execution block
package exec_pkg;
   // AXI4-Lite geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ACC = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0C;
   localparam logic [7:0] OFS_PUSH = 8'h10;
   localparam logic [7:0] OFS_FADDR = 8'h14;
   localparam logic [7:0] OFS_FDATA = 8'h18;
   localparam logic [7:0] OFS_WDT = 8'h1C;
   localparam logic [7:0] OFS_WAKE = 8'h20;

   // instruction codes in the command register
   localparam logic [3:0] OPC_RETURN = 4'h1;
   localparam logic [3:0] OPC_SLEEP = 4'h2;
   localparam logic [3:0] OPC_LIT_SUB = 4'h3;
   localparam logic [3:0] OPC_LIT_XOR = 4'h4;
   localparam logic [3:0] OPC_REG_SUB = 4'h5;
   localparam logic [3:0] OPC_REG_XOR = 4'h6;
   localparam logic [3:0] OPC_NIB_SWAP = 4'h7;

   // core geometry
   localparam int PC_W = 13;
   localparam int STK_DEPTH = 8;
   localparam int STK_PTR_W = 3;
   localparam int FILE_DEPTH = 128;
   localparam int FADDR_W = 7;
   localparam int WDT_W = 8;
   localparam int PRE_W = 8;

   // status register extra bit positions
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_SLEEP_BIT = 9;

   // command word layout
   typedef struct packed {
      logic [7:0] lit;
      logic [7:0] rsv_hi;
      logic rsv_mid;
      logic [FADDR_W-1:0] faddr;
      logic [2:0] rsv_lo;
      logic dest;
      logic [3:0] opc;
   } cmd_t;

   // status flags, power-down and time-out kept active low
   typedef struct packed {
      logic watchdog_expiry_flag_n;
      logic powerdown_flag_n;
      logic result_nil_flag;
      logic nibble_carry_bit;
      logic borrow_out_bit;
   } flags_t;

   localparam flags_t FLAGS_RST = 5'h18;
   localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
   localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;

   typedef enum logic [2:0] {
      ALU_PASS, ALU_LIT_SUB, ALU_LIT_XOR, ALU_REG_SUB, ALU_REG_XOR, ALU_SWAP
   } alu_op_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2} exec_st_t;
endpackage

// >>> core/exec_alu.sv
// datapath for subtract, exclusive-or and nibble exchange
`timescale 1ns/1ps
module exec_alu (
   // operation select
   input wire exec_pkg::alu_op_t op,
   // operands
   input wire logic [7:0] acc,
   input wire logic [7:0] operand,
   // result and flags
   output logic [7:0] res,
   output logic c,
   output logic dc,
   output logic z,
   output logic upd_c,
   output logic upd_z
);
   import exec_pkg::*;

   always_comb begin
      res = operand;
      upd_c = 1'b0;
      upd_z = 1'b0;
      unique case (op)
         ALU_LIT_SUB, ALU_REG_SUB: begin
            res = operand - acc;
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         ALU_LIT_XOR, ALU_REG_XOR: begin
            res = operand ^ acc;
            upd_z = 1'b1;
         end
         ALU_SWAP: res = {operand[3:0], operand[7:4]};
         ALU_PASS: res = operand;
      endcase
      // a set carry means no borrow was needed
      c = (operand >= acc);
      dc = (operand[3:0] >= acc[3:0]);
      z = (res == 8'h00);
   end
endmodule

// >>> core/exec_top.sv
// instruction execution unit with its AXI4-Lite register slave
// Behaviour
// - return pops the stack into the program counter, flags untouched
// - return occupies two instruction cycles
// - low-power entry clears watchdog counter and its prescaler
// - low-power entry clears powerdown flag, sets expiry flag, nothing else
// - after low-power entry the oscillator is halted
// - literal minus accumulator into accumulator, updates C, DC, Z
// - literal xor accumulator into accumulator, updates only Z
// - file register minus accumulator, updates C, DC, Z, address 0..127
// - destination bit 0 writes accumulator, 1 writes the file register
// - file register xor accumulator to destination, updates only Z
// - nibble exchange of file register to destination, no flags
`timescale 1ns/1ps
module exec_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // write address channel
   input wire logic [exec_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // write data channel
   input wire logic [exec_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // write response channel
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // read address channel
   input wire logic [exec_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // read data channel
   output logic [exec_pkg::DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // power state
   output logic OSC_HALT
);
   import exec_pkg::*;

   // bus slave state
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   // core state
   exec_st_t st_q, st_d;
   cmd_t cmd_q, cmd_d;
   flags_t flags_q, flags_d;
   logic [7:0] acc_q, acc_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [STK_PTR_W-1:0] sp_q, sp_d;
   logic [FADDR_W-1:0] faddr_q, faddr_d;
   logic [WDT_W-1:0] wdt_q, wdt_d;
   logic [PRE_W-1:0] pre_q, pre_d;
   logic sleep_q, sleep_d;
   logic [7:0] file_q [FILE_DEPTH];
   logic [PC_W-1:0] stk_q [STK_DEPTH];
   // memory write ports
   logic file_we, stk_we;
   logic [FADDR_W-1:0] file_wa;
   logic [7:0] file_wd;
   logic [PC_W-1:0] stk_wd;
   // datapath
   alu_op_t alu_op;
   logic [7:0] operand, alu_res;
   logic alu_c, alu_dc, alu_z, alu_upd_c, alu_upd_z;
   logic wr_go, ex_go;
   logic [DATA_W-1:0] wr_img;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      unique case (a[ADDR_W-1:2])
         OFS_CMD[7:2], OFS_STATUS[7:2], OFS_ACC[7:2], OFS_PC[7:2],
         OFS_PUSH[7:2], OFS_FADDR[7:2], OFS_FDATA[7:2], OFS_WDT[7:2],
         OFS_WAKE[7:2]: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] reg_image(
      input logic [ADDR_W-1:0] a);
      reg_image = 32'h0000_0000;
      unique case (a[ADDR_W-1:2])
         OFS_CMD[7:2]: reg_image = cmd_q;
         OFS_STATUS[7:2]: begin
            reg_image[4:0] = flags_q;
            reg_image[STAT_BUSY_BIT] = (st_q != ST_IDLE);
            reg_image[STAT_SLEEP_BIT] = sleep_q;
         end
         OFS_ACC[7:2]: reg_image[7:0] = acc_q;
         OFS_PC[7:2]: reg_image[PC_W-1:0] = pc_q;
         OFS_PUSH[7:2]: reg_image[STK_PTR_W-1:0] = sp_q;
         OFS_FADDR[7:2]: reg_image[FADDR_W-1:0] = faddr_q;
         OFS_FDATA[7:2]: reg_image[7:0] = file_q[faddr_q];
         OFS_WDT[7:2]: reg_image[15:0] = {pre_q, wdt_q};
         default: reg_image = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction

   // operand and operation select for the current instruction
   always_comb begin
      operand = file_q[cmd_q.faddr];
      unique case (cmd_q.opc)
         OPC_LIT_SUB: alu_op = ALU_LIT_SUB;
         OPC_LIT_XOR: alu_op = ALU_LIT_XOR;
         OPC_REG_SUB: alu_op = ALU_REG_SUB;
         OPC_REG_XOR: alu_op = ALU_REG_XOR;
         OPC_NIB_SWAP: alu_op = ALU_SWAP;
         default: alu_op = ALU_PASS;
      endcase
      if (cmd_q.opc == OPC_LIT_SUB || cmd_q.opc == OPC_LIT_XOR) begin
         operand = cmd_q.lit;
      end
   end

   exec_alu u_alu (
      .op(alu_op),
      .acc(acc_q),
      .operand(operand),
      .res(alu_res),
      .c(alu_c),
      .dc(alu_dc),
      .z(alu_z),
      .upd_c(alu_upd_c),
      .upd_z(alu_upd_z)
   );

   // bus channels: address and data are taken in either order
   always_comb begin
      aw_have_d = aw_have_q;
      awaddr_d = awaddr_q;
      w_have_d = w_have_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (S_AXI_AWVALID && awready_q) begin
         aw_have_d = 1'b1;
         awaddr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_q) begin
         w_have_d = 1'b1;
         wdata_d = S_AXI_WDATA;
         wstrb_d = S_AXI_WSTRB;
      end
      wr_go = aw_have_q && w_have_q && !bvalid_q;
      wr_img = merge(reg_image(awaddr_q), wdata_q, wstrb_q);
      if (wr_go) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
         bvalid_d = 1'b0;
      end
      if (S_AXI_ARVALID && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d = reg_image(S_AXI_ARADDR);
         rresp_d = is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   // execution, watchdog and register writes
   always_comb begin
      st_d = st_q;
      cmd_d = cmd_q;
      flags_d = flags_q;
      acc_d = acc_q;
      pc_d = pc_q;
      sp_d = sp_q;
      faddr_d = faddr_q;
      sleep_d = sleep_q;
      file_we = 1'b0;
      file_wa = faddr_q;
      file_wd = wr_img[7:0];
      stk_we = 1'b0;
      stk_wd = wr_img[PC_W-1:0];
      ex_go = (st_q == ST_EXEC);
      // watchdog keeps counting in sleep; a wrap is a time-out
      pre_d = pre_q + 8'h01;
      wdt_d = wdt_q;
      if (pre_q == '1) begin
         wdt_d = wdt_q + 8'h01;
         if (wdt_q == '1) begin
            flags_d.watchdog_expiry_flag_n = 1'b0;
            sleep_d = 1'b0;
         end
      end
      if (wr_go && is_mapped(awaddr_q)) begin
         unique case (awaddr_q[ADDR_W-1:2])
            OFS_CMD[7:2]: begin
               // a command while busy or asleep is dropped
               if (st_q == ST_IDLE && !sleep_q) begin
                  cmd_d = wr_img;
                  st_d = ST_EXEC;
               end
            end
            OFS_ACC[7:2]: acc_d = wr_img[7:0];
            OFS_PC[7:2]: pc_d = wr_img[PC_W-1:0];
            OFS_PUSH[7:2]: begin
               stk_we = 1'b1;
               sp_d = sp_q + 3'h1;
            end
            OFS_FADDR[7:2]: faddr_d = wr_img[FADDR_W-1:0];
            OFS_FDATA[7:2]: file_we = 1'b1;
            OFS_WAKE[7:2]: sleep_d = 1'b0;
            default: ;
         endcase
      end
      if (st_q == ST_RET2) begin
         st_d = ST_IDLE;
      end
      if (ex_go) begin
         st_d = ST_IDLE;
         pc_d = pc_q + 13'h0001;
         case (cmd_q.opc)
            OPC_RETURN: begin
               sp_d = sp_q - 3'h1;
               pc_d = stk_q[sp_q - 3'h1];
               st_d = ST_RET2;
            end
            OPC_SLEEP: begin
               wdt_d = WDT_CLEAR;
               pre_d = PRE_CLEAR;
               flags_d.powerdown_flag_n = 1'b0;
               flags_d.watchdog_expiry_flag_n = 1'b1;
               sleep_d = 1'b1;
            end
            OPC_LIT_SUB, OPC_LIT_XOR, OPC_REG_SUB, OPC_REG_XOR,
            OPC_NIB_SWAP: begin
               if (alu_upd_c) begin
                  flags_d.borrow_out_bit = alu_c;
                  flags_d.nibble_carry_bit = alu_dc;
               end
               if (alu_upd_z) begin
                  flags_d.result_nil_flag = alu_z;
               end
               // literal forms always land in the accumulator
               if (cmd_q.dest && cmd_q.opc != OPC_LIT_SUB &&
                   cmd_q.opc != OPC_LIT_XOR) begin
                  file_we = 1'b1;
                  file_wa = cmd_q.faddr;
                  file_wd = alu_res;
               end else begin
                  acc_d = alu_res;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_have_q <= 1'b0;
         awaddr_q <= '0;
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         st_q <= ST_IDLE;
         cmd_q <= '0;
         flags_q <= FLAGS_RST;
         acc_q <= '0;
         pc_q <= '0;
         sp_q <= '0;
         faddr_q <= '0;
         wdt_q <= WDT_CLEAR;
         pre_q <= PRE_CLEAR;
         sleep_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         awaddr_q <= awaddr_d;
         w_have_q <= w_have_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         st_q <= st_d;
         cmd_q <= cmd_d;
         flags_q <= flags_d;
         acc_q <= acc_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         faddr_q <= faddr_d;
         wdt_q <= wdt_d;
         pre_q <= pre_d;
         sleep_q <= sleep_d;
      end
   end

   // arrays carry no reset; software initialises what it reads
   always_ff @(posedge CLK) begin
      if (file_we) begin
         file_q[file_wa] <= file_wd;
      end
      if (stk_we) begin
         stk_q[sp_q] <= stk_wd;
      end
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign OSC_HALT = sleep_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_exec(logic [3:0] code);
      st_q == ST_EXEC && cmd_q.opc == code;
   endsequence
   sequence s_ret_tail;
      (st_q == ST_RET2) ##1 (st_q == ST_IDLE);
   endsequence

   property p_ret_pc;
      s_exec(OPC_RETURN) |=> pc_q == $past(stk_q[sp_q - 3'h1]) &&
         sp_q == $past(sp_q) - 3'h1 && flags_q == $past(flags_q);
   endproperty
   a_ret_pc: assert property (p_ret_pc)
      else $error("return did not load pc from stack head");
   property p_ret_two;
      s_exec(OPC_RETURN) |=> s_ret_tail;
   endproperty
   a_ret_two: assert property (p_ret_two)
      else $error("return did not take two cycles");
   property p_sleep_wdt;
      s_exec(OPC_SLEEP) |=> wdt_q == WDT_CLEAR && pre_q == PRE_CLEAR;
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt)
      else $error("watchdog not cleared by sleep");
   property p_sleep_flags;
      s_exec(OPC_SLEEP) |=> !flags_q.powerdown_flag_n &&
         flags_q.watchdog_expiry_flag_n &&
         flags_q[2:0] == $past(flags_q[2:0]);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags)
      else $error("sleep flag update wrong");
   property p_sleep_halt;
      s_exec(OPC_SLEEP) |=> OSC_HALT [*2];
   endproperty
   a_sleep_halt: assert property (p_sleep_halt)
      else $error("oscillator not halted after sleep");
   property p_lit_sub;
      s_exec(OPC_LIT_SUB) |=> acc_q == $past(cmd_q.lit - acc_q) &&
         flags_q.borrow_out_bit == ($past(cmd_q.lit) >= $past(acc_q)) &&
         flags_q.result_nil_flag == (acc_q == 8'h00);
   endproperty
   a_lit_sub: assert property (p_lit_sub)
      else $error("literal subtract wrong");
   property p_lit_xor;
      s_exec(OPC_LIT_XOR) |=> acc_q == $past(cmd_q.lit ^ acc_q) &&
         flags_q[1:0] == $past(flags_q[1:0]);
   endproperty
   a_lit_xor: assert property (p_lit_xor)
      else $error("literal xor wrong");
   property p_reg_sub_nib;
      s_exec(OPC_REG_SUB) |=> flags_q.nibble_carry_bit ==
         ($past(operand[3:0]) >= $past(acc_q[3:0]));
   endproperty
   a_reg_sub_nib: assert property (p_reg_sub_nib)
      else $error("register subtract nibble carry wrong");
   property p_dest_file;
      st_q == ST_EXEC && cmd_q.dest && cmd_q.opc >= OPC_REG_SUB &&
         cmd_q.opc <= OPC_NIB_SWAP |=> acc_q == $past(acc_q) &&
         file_q[$past(cmd_q.faddr)] == $past(alu_res);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("file destination not written");
   property p_swap;
      s_exec(OPC_NIB_SWAP) |=> flags_q == $past(flags_q);
   endproperty
   a_swap: assert property (p_swap)
      else $error("nibble exchange changed flags");
endmodule

// >>> test/tb.sv
// self-checking bench for the instruction execution unit
`timescale 1ns/1ps
module tb;
   import exec_pkg::*;
   logic clk, rstn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, osc_halt;
   logic [1:0] bresp, rresp;
   int n_mismatch, checks;
   // reference state of the core, updated only from the expected behaviour
   logic [7:0] m_acc;
   logic [7:0] m_file [0:127];
   logic [12:0] m_pc;
   logic [4:0] m_fl;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   exec_top dut (
      .CLK(clk), .RSTN(rstn),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready),
      .OSC_HALT(osc_halt)
   );

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // address and data are offered together and each dropped once taken;
   // waits are open ended, only the watchdog ends a hung transfer
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin
         @(posedge clk);
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   task setf(input logic [6:0] fa, input logic [7:0] v);
      wr(OFS_FADDR, {25'h0, fa}, RESP_OKAY);
      wr(OFS_FDATA, {24'h0, v}, RESP_OKAY);
      m_file[fa] = v;
   endtask

   task cmd(input logic [3:0] op, input logic dst, input logic [6:0] fa,
            input logic [7:0] lit);
      cmd_t c;
      c = '0;
      c.opc = op;
      c.dest = dst;
      c.faddr = fa;
      c.lit = lit;
      wr(OFS_CMD, c, RESP_OKAY);
      // return keeps the core busy for two cycles after the commit
      repeat (3) @(posedge clk);
   endtask

   task run(input logic [3:0] op, input logic dst, input logic [6:0] fa,
            input logic [7:0] lit);
      logic [7:0] opd, r;
      logic is_lit;
      is_lit = (op == OPC_LIT_SUB || op == OPC_LIT_XOR);
      opd = is_lit ? lit : m_file[fa];
      if (op == OPC_LIT_XOR || op == OPC_REG_XOR) r = opd ^ m_acc;
      else if (op == OPC_NIB_SWAP) r = {opd[3:0], opd[7:4]};
      else r = opd - m_acc;
      if (op == OPC_LIT_SUB || op == OPC_REG_SUB)
         m_fl[1:0] = {opd[3:0] >= m_acc[3:0], opd >= m_acc};
      if (op != OPC_NIB_SWAP) m_fl[2] = (r == 8'h00);
      if (dst && !is_lit) m_file[fa] = r;
      else m_acc = r;
      m_pc = m_pc + 13'h0001;
      wr(OFS_FADDR, {25'h0, fa}, RESP_OKAY);
      cmd(op, dst, fa, lit);
      rd(OFS_ACC, rv, RESP_OKAY);
      chk(rv, {24'h0, m_acc});
      rd(OFS_FDATA, rv, RESP_OKAY);
      chk(rv, {24'h0, m_file[fa]});
      rd(OFS_STATUS, rv, RESP_OKAY);
      chk(rv, {27'h0, m_fl});
      rd(OFS_PC, rv, RESP_OKAY);
      chk(rv, {19'h0, m_pc});
   endtask

   task ret(input logic [12:0] epc, input logic [31:0] eptr);
      cmd(OPC_RETURN, 1'b0, 7'h00, 8'h00);
      m_pc = epc;
      rd(OFS_PC, rv, RESP_OKAY);
      chk(rv, {19'h0, epc});
      rd(OFS_PUSH, rv, RESP_OKAY);
      chk(rv, eptr);
      rd(OFS_STATUS, rv, RESP_OKAY);
      chk(rv, {27'h0, m_fl});
   endtask

   // the whole sequence needs somewhat over a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      rstn = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      n_mismatch = 0;
      checks = 0;
      m_acc = 8'h00;
      m_pc = 13'h0000;
      m_fl = FLAGS_RST;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd(OFS_STATUS, rv, RESP_OKAY);
      chk(rv, 32'h0000_0018);
      rd(OFS_ACC, rv, RESP_OKAY);
      chk(rv, 32'h0000_0000);
      // unmapped place and read-only register
      rd(8'h24, rv, RESP_SLVERR);
      chk(rv, 32'h0000_0000);
      wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_STATUS, rv, RESP_OKAY);
      chk(rv, 32'h0000_0018);
      setf(7'h00, 8'h3C);
      setf(7'h7F, 8'h81);
      setf(7'h05, 8'h06);
      wr(OFS_ACC, 32'h0000_0005, RESP_OKAY);
      m_acc = 8'h05;
      // borrow in both nibbles, then zero results and back to nonzero
      run(OPC_LIT_SUB, 1'b1, 7'h00, 8'h03);
      run(OPC_LIT_XOR, 1'b1, 7'h00, 8'hFE);
      run(OPC_LIT_SUB, 1'b0, 7'h00, 8'h00);
      run(OPC_LIT_XOR, 1'b0, 7'h00, 8'hA5);
      run(OPC_REG_SUB, 1'b0, 7'h7F, 8'h00);
      run(OPC_REG_SUB, 1'b1, 7'h00, 8'h00);
      run(OPC_REG_XOR, 1'b1, 7'h7F, 8'h00);
      run(OPC_REG_XOR, 1'b0, 7'h00, 8'h00);
      run(OPC_NIB_SWAP, 1'b1, 7'h7F, 8'h00);
      run(OPC_NIB_SWAP, 1'b0, 7'h00, 8'h00);
      wr(OFS_ACC, 32'h0000_0006, RESP_OKAY);
      m_acc = 8'h06;
      run(OPC_REG_SUB, 1'b1, 7'h05, 8'h00);
      run(OPC_REG_XOR, 1'b0, 7'h05, 8'h00);
      // two nested returns unwind in reverse order
      wr(OFS_PC, 32'h0000_0050, RESP_OKAY);
      wr(OFS_PUSH, 32'h0000_1234, RESP_OKAY);
      wr(OFS_PUSH, 32'h0000_0ABC, RESP_OKAY);
      rd(OFS_PUSH, rv, RESP_OKAY);
      chk(rv, 32'h0000_0002);
      ret(13'h0ABC, 32'h0000_0001);
      ret(13'h1234, 32'h0000_0000);
      // let the watchdog count up so the clear is visible
      repeat (600) @(posedge clk);
      cmd(OPC_SLEEP, 1'b0, 7'h00, 8'h00);
      m_pc = m_pc + 13'h0001;
      m_fl[4:3] = 2'b10;
      chk({31'h0, osc_halt}, 32'h0000_0001);
      rd(OFS_WDT, rv, RESP_OKAY);
      chk({24'h0, rv[7:0]}, {24'h0, WDT_CLEAR});
      chk({31'h0, rv[15:8] < 8'h20}, 32'h0000_0001);
      rd(OFS_STATUS, rv, RESP_OKAY);
      chk(rv, {22'h0, 1'b1, 4'h0, m_fl});
      // a command offered while halted must not execute
      cmd(OPC_LIT_XOR, 1'b0, 7'h00, 8'hFF);
      rd(OFS_ACC, rv, RESP_OKAY);
      chk(rv, {24'h0, m_acc});
      rd(OFS_PC, rv, RESP_OKAY);
      chk(rv, {19'h0, m_pc});
      wr(OFS_WAKE, 32'h0000_0000, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({31'h0, osc_halt}, 32'h0000_0000);
      close_out();
   end
endmodule
